// >>> pth_pkg.sv
// Shared constants, encodings and carrier types for the threshold block.
// Assumes one 100 MHz clock domain for all users of these definitions.
package pth_pkg;

    // Register offsets on the register-address port.
    localparam logic [7:0] PTH_OFS_ANT_A_PROX = 8'h60;
    localparam logic [7:0] PTH_OFS_ANT_A_TOUCH = 8'h61;
    localparam logic [7:0] PTH_OFS_BAND = 8'h80;
    localparam logic [7:0] PTH_OFS_HALT = 8'h81;
    localparam logic [7:0] PTH_OFS_PROX = 8'h82;
    localparam logic [7:0] PTH_OFS_TOUCH = 8'h83;

    // Reset values.
    localparam logic [7:0] PTH_RST_ANT_A_PROX = 8'h00;
    localparam logic [7:0] PTH_RST_ANT_A_TOUCH = 8'h00;
    localparam logic [7:0] PTH_RST_BAND = 8'ha2;
    localparam logic [7:0] PTH_RST_HALT = 8'h0a;
    localparam logic [7:0] PTH_RST_PROX = 8'h16;
    localparam logic [7:0] PTH_RST_TOUCH = 8'h25;

    // Release band field layout: touch in bits 5-4, proximity in bits 1-0.
    localparam int PTH_BAND_T_LSB = 4;
    localparam int PTH_BAND_P_LSB = 0;
    localparam logic [7:0] PTH_BAND_MASK = 8'h33;

    // Scaling of touch thresholds.
    localparam int PTH_TOUCH_SHIFT = 2;
    localparam int PTH_LTA_SHIFT = 8;

    // Width of counts, averages and effective thresholds.
    localparam int PTH_MEAS_W = 16;

    // Release band selection.
    typedef enum logic [1:0] {
        PTH_BAND_OFF,
        PTH_BAND_QUARTER,
        PTH_BAND_EIGHTH,
        PTH_BAND_SIXTEENTH
    } pth_band_e;

    // One measurement sample from the front end.
    typedef struct packed {
        logic valid;
        logic [PTH_MEAS_W-1:0] delta;
        logic [PTH_MEAS_W-1:0] long_term_average;
    } pth_meas_s;

    // Register access request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pth_reg_req_s;

    // Detection outputs.
    typedef struct packed {
        logic prox;
        logic touch;
        logic halt;
    } pth_state_s;

endpackage

// >>> pth_hyst_det.sv
// One detection level with set threshold and release band.
// Assumes delta, threshold and band are stable in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module pth_hyst_det #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sample,
    input wire logic [W-1:0] delta,
    input wire logic [W-1:0] threshold,
    input wire pth_pkg::pth_band_e band,
    output logic active
);
    import pth_pkg::*;

    logic active_reg;
    logic active_next;
    logic [W-1:0] release_lvl;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Release level is the threshold less the selected fraction of it.
    always_comb begin
        unique case (band)
            PTH_BAND_OFF: release_lvl = threshold;
            PTH_BAND_QUARTER: release_lvl = threshold - (threshold >> 2);
            PTH_BAND_EIGHTH: release_lvl = threshold - (threshold >> 3);
            PTH_BAND_SIXTEENTH: release_lvl = threshold - (threshold >> 4);
        endcase
    end

    // Set on reaching the threshold, clear only below the release level.
    always_comb begin
        active_next = active_reg;
        if (sample) begin
            if (!active_reg) begin
                active_next = (delta >= threshold);
            end else begin
                active_next = (delta >= release_lvl);
            end
        end
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= active_next;
        end
    end

    assign active = active_reg;

    det_set_a: assert property (
        sample && !active_reg && delta >= threshold |=> active_reg)
        else $error("Detector did not set at threshold.");
    det_hold_a: assert property (
        sample && active_reg && delta >= release_lvl |=> active_reg)
        else $error("Detector released above release level.");
    det_drop_a: assert property (
        sample && active_reg && delta < release_lvl |=> !active_reg)
        else $error("Detector held below release level.");
    det_band_a: assert property (
        band == PTH_BAND_EIGHTH |->
        release_lvl + (threshold >> 3) == threshold)
        else $error("Eighth release band miscomputed.");

endmodule
`default_nettype wire

// >>> pth_threshold_ui.sv
// Threshold and release band configuration with proximity/touch detection.
// Assumes register requests and samples come from logic on clk.
// What this block does
// - Touch band 00 off; 01, 10, 11 take 1/4, 1/8, 1/16 of threshold.
// - Proximity band uses the same encoding on the proximity threshold.
// - Single-channel filter halt level zero halts always; otherwise delta at level halts.
// - Single-channel proximity threshold is the proximity level register.
// - Single-channel touch threshold is touch level register times four.
// - Two-channel exposure mode forces both release band fields to zero.
// - Two-channel first antenna proximity threshold is its register value.
// - First antenna touch threshold is register times average over 256.
`timescale 1ns/1ps
`default_nettype none
module pth_threshold_ui (
    input wire logic clk,
    input wire logic resetn,
    input wire logic dual_mode,
    input wire pth_pkg::pth_reg_req_s reg_req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire pth_pkg::pth_meas_s meas,
    output pth_pkg::pth_state_s status,
    output logic [pth_pkg::PTH_MEAS_W-1:0] eff_prox_th,
    output logic [pth_pkg::PTH_MEAS_W-1:0] eff_touch_th
);
    import pth_pkg::*;

    localparam int W = PTH_MEAS_W;

    logic [7:0] ant_prox_reg, ant_prox_next;
    logic [7:0] ant_touch_reg, ant_touch_next;
    logic [7:0] band_reg, band_next;
    logic [7:0] halt_lvl_reg, halt_lvl_next;
    logic [7:0] prox_lvl_reg, prox_lvl_next;
    logic [7:0] touch_lvl_reg, touch_lvl_next;
    logic [7:0] rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next;
    logic [W-1:0] lta_reg, lta_next;
    logic [W-1:0] prox_th_reg, prox_th_next;
    logic [W-1:0] touch_th_reg, touch_th_next;
    logic halt_reg, halt_next;
    logic [W+7:0] lta_prod;
    logic [W-1:0] det_th [2];
    pth_band_e det_band [2];
    logic [1:0] det_active;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Register writes and read data selection.
    always_comb begin
        ant_prox_next = ant_prox_reg;
        ant_touch_next = ant_touch_reg;
        band_next = band_reg;
        halt_lvl_next = halt_lvl_reg;
        prox_lvl_next = prox_lvl_reg;
        touch_lvl_next = touch_lvl_reg;
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                PTH_OFS_ANT_A_PROX: ant_prox_next = reg_req.wdata;
                PTH_OFS_ANT_A_TOUCH: ant_touch_next = reg_req.wdata;
                PTH_OFS_BAND: band_next = (band_reg & ~PTH_BAND_MASK) |
                    (reg_req.wdata & PTH_BAND_MASK);
                PTH_OFS_HALT: halt_lvl_next = reg_req.wdata;
                PTH_OFS_PROX: prox_lvl_next = reg_req.wdata;
                PTH_OFS_TOUCH: touch_lvl_next = reg_req.wdata;
                default: ;
            endcase
        end
        if (dual_mode) begin
            band_next = band_next & ~PTH_BAND_MASK;
        end
        rd_valid_next = reg_req.rd;
        unique case (reg_req.addr)
            PTH_OFS_ANT_A_PROX: rd_data_next = ant_prox_reg;
            PTH_OFS_ANT_A_TOUCH: rd_data_next = ant_touch_reg;
            PTH_OFS_BAND: rd_data_next = band_reg;
            PTH_OFS_HALT: rd_data_next = halt_lvl_reg;
            PTH_OFS_PROX: rd_data_next = prox_lvl_reg;
            PTH_OFS_TOUCH: rd_data_next = touch_lvl_reg;
            default: rd_data_next = 8'h00;
        endcase
        if (!reg_req.rd) begin
            rd_data_next = rd_data_reg;
        end
    end

    // Configuration registers and read answer.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ant_prox_reg <= PTH_RST_ANT_A_PROX;
            ant_touch_reg <= PTH_RST_ANT_A_TOUCH;
            band_reg <= PTH_RST_BAND;
            halt_lvl_reg <= PTH_RST_HALT;
            prox_lvl_reg <= PTH_RST_PROX;
            touch_lvl_reg <= PTH_RST_TOUCH;
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            ant_prox_reg <= ant_prox_next;
            ant_touch_reg <= ant_touch_next;
            band_reg <= band_next;
            halt_lvl_reg <= halt_lvl_next;
            prox_lvl_reg <= prox_lvl_next;
            touch_lvl_reg <= touch_lvl_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    // Effective thresholds for the selected mode, and the halt decision.
    always_comb begin
        lta_next = meas.valid ? meas.long_term_average : lta_reg;
        lta_prod = ant_touch_reg * lta_reg;
        if (dual_mode) begin
            prox_th_next = {{(W-8){1'b0}}, ant_prox_reg};
            touch_th_next = lta_prod[W+7:PTH_LTA_SHIFT];
        end else begin
            prox_th_next = {{(W-8){1'b0}}, prox_lvl_reg};
            touch_th_next = {{(W-10){1'b0}}, touch_lvl_reg,
                {PTH_TOUCH_SHIFT{1'b0}}};
        end
        halt_next = halt_reg;
        if (meas.valid) begin
            halt_next = !dual_mode && (halt_lvl_reg == 8'h00 ||
                meas.delta >= {{(W-8){1'b0}}, halt_lvl_reg});
        end
    end

    // Threshold, average and halt registers.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lta_reg <= '0;
            prox_th_reg <= '0;
            touch_th_reg <= '0;
            halt_reg <= 1'b0;
        end else begin
            lta_reg <= lta_next;
            prox_th_reg <= prox_th_next;
            touch_th_reg <= touch_th_next;
            halt_reg <= halt_next;
        end
    end

    // Detector inputs: index 0 is proximity, index 1 is touch.
    assign det_th[0] = prox_th_reg;
    assign det_th[1] = touch_th_reg;
    assign det_band[0] = pth_band_e'(band_reg[PTH_BAND_P_LSB +: 2]);
    assign det_band[1] = pth_band_e'(band_reg[PTH_BAND_T_LSB +: 2]);

    // One hysteresis detector per detection level.
    for (genvar i = 0; i < 2; i++) begin : g_det
        pth_hyst_det #(
            .W(W)
        ) u_det (
            .clk(clk),
            .resetn(resetn),
            .sample(meas.valid),
            .delta(meas.delta),
            .threshold(det_th[i]),
            .band(det_band[i]),
            .active(det_active[i])
        );
    end

    assign status.prox = det_active[0];
    assign status.touch = det_active[1];
    assign status.halt = halt_reg;
    assign eff_prox_th = prox_th_reg;
    assign eff_touch_th = touch_th_reg;
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;

    // Steps of a proximity level write, used by the write check below.
    sequence s_prox_wr;
        reg_req.wr && reg_req.addr == PTH_OFS_PROX;
    endsequence
    sequence s_single_next;
        ##1 !dual_mode ##1 1'b1;
    endsequence

    band_forced_a: assert property (
        $past(dual_mode) |-> (band_reg & PTH_BAND_MASK) == 8'h00)
        else $error("Release bands not zero in two-channel mode.");
    prox_direct_a: assert property (
        !dual_mode |=> prox_th_reg == {8'h00, $past(prox_lvl_reg)})
        else $error("Single-channel proximity threshold wrong.");
    prox_write_a: assert property (
        s_prox_wr ##0 s_single_next |-> prox_th_reg == {8'h00,
        $past(reg_req.wdata, 2)})
        else $error("Written proximity level not applied in two cycles.");
    ant_prox_a: assert property (
        dual_mode |=> prox_th_reg == {8'h00, $past(ant_prox_reg)})
        else $error("First antenna proximity threshold wrong.");
    touch_scale_a: assert property (
        !dual_mode |=> touch_th_reg == 16'h0004 * $past(touch_lvl_reg))
        else $error("Touch threshold not four times level.");
    touch_lta_a: assert property (
        dual_mode |=> touch_th_reg == 16'((24'h00_0000 +
        $past(ant_touch_reg) * $past(lta_reg)) >> 8))
        else $error("First antenna touch threshold wrong.");
    halt_zero_a: assert property (
        meas.valid && !dual_mode && halt_lvl_reg == 8'h00 |=> halt_reg)
        else $error("Zero halt level did not halt.");
    halt_cmp_a: assert property (
        meas.valid && !dual_mode && halt_lvl_reg != 8'h00 |=>
        halt_reg == ($past(meas.delta) >= {8'h00, $past(halt_lvl_reg)}))
        else $error("Halt decision disagrees with level.");
    read_answer_a: assert property (
        reg_req.rd |=> rd_valid ##1 (rd_valid == $past(reg_req.rd)))
        else $error("Read answer timing wrong.");

    // Top-level checks that each detector is fed its own threshold and that halt is low after each sample taken in two-channel mode.
    prox_wire_a: assert property (
        meas.valid && !status.prox && meas.delta >= prox_th_reg |=>
        status.prox)
        else $error("Proximity did not set at its threshold.");
    touch_wire_a: assert property (
        meas.valid && !status.touch && meas.delta >= touch_th_reg |=>
        status.touch)
        else $error("Touch did not set at its threshold.");
    halt_dual_a: assert property (
        meas.valid && dual_mode |=> !status.halt)
        else $error("Filter halt raised in two-channel mode.");
    // Bits outside the release band fields keep their reset value.
    fixed_bits_a: assert property (
        (band_reg & ~PTH_BAND_MASK) == (PTH_RST_BAND & ~PTH_BAND_MASK))
        else $error("Fixed release band bits changed.");

endmodule
`default_nettype wire

// >>> pth_host_model.sv
// Host model that issues single-byte register writes and reads.
// Assumes the bench calls its task from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module pth_host_model (
    input wire logic clk,
    output var pth_pkg::pth_reg_req_s reg_req
);
    import pth_pkg::*;
    // The port starts idle with no strobe raised.
    initial begin
        reg_req = '0;
    end
    // Holds one request for one edge, then scrambles the released fields.
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule
`default_nettype wire

// >>> pth_threshold_ui_bench.sv
// Self-checking bench for the threshold and release band block.
// Assumes the host model drives the register port of the block.
`timescale 1ns/1ps
`default_nettype none
module pth_threshold_ui_bench;
    import pth_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b1;
    logic dual_mode = 1'b0;
    pth_reg_req_s reg_req;
    pth_meas_s meas = '0;
    logic [7:0] rd_data;
    logic rd_valid;
    pth_state_s status;
    logic [15:0] eff_prox_th;
    logic [15:0] eff_touch_th;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] exp_q[$];
    logic [31:0] rnd = 32'h8bdb;
    logic [7:0] ofs_tab[7] = '{8'h60, 8'h61, 8'h80, 8'h81, 8'h82, 8'h83,
        8'h90};
    logic [7:0] rst_tab[7] = '{8'h00, 8'h00, 8'ha2, 8'h0a, 8'h16, 8'h25,
        8'h00};
    logic [7:0] halt_tab[3] = '{8'h00, 8'h0a, 8'hfe};
    logic [15:0] rel;
    logic [15:0] rel_t, rel_hi, rel_lo;

    // The clock toggles every half period of 5 ns.
    always #5 clk = ~clk;

    pth_threshold_ui i_pth_threshold_ui (.clk(clk), .resetn(resetn),
        .dual_mode(dual_mode), .reg_req(reg_req), .rd_data(rd_data),
        .rd_valid(rd_valid), .meas(meas), .status(status),
        .eff_prox_th(eff_prox_th), .eff_touch_th(eff_touch_th));
    pth_host_model i_pth_host_model (.clk(clk), .reg_req(reg_req));

    // Steps the shift register used for random register values.
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Compares one value and reports a difference at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // A write lets the effective thresholds settle before returning.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_pth_host_model.access(1'b1, a, d);
        repeat (2) @(posedge clk);
    endtask

    // A read notes its expected answer before the request goes out.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_pth_host_model.access(1'b0, a, 8'h00);
    endtask

    // One sample pulse; returns once the status has been updated.
    task automatic sample(input logic [15:0] d, input logic [15:0] l);
        @(posedge clk);
        meas <= '{valid: 1'b1, delta: d, long_term_average: l};
        @(posedge clk);
        meas <= '{valid: 1'b0, delta: ~d, long_term_average: l};
        @(posedge clk);
        #1;
    endtask

    // Takes the oldest noted read result whenever an answer appears.
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check({8'h00, rd_data}, 16'hdead);
            end else begin
                check({8'h00, rd_data}, {8'h00, exp_q.pop_front()});
            end
        end
    end

    // Cuts a hang short after a cycle ceiling.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            print_verdict();
        end
    end

    // Main sequence of scenarios.
    initial begin
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(ofs_tab[i], rst_tab[i]);
        end
        check(eff_prox_th, 16'h0016);
        check(eff_touch_th, 16'h0094);
        wr(PTH_OFS_BAND, 8'hff);
        rd(PTH_OFS_BAND, 8'hb3);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr_next(rnd);
            wr(PTH_OFS_PROX, rnd[7:0]);
            wr(PTH_OFS_TOUCH, rnd[15:8]);
            check(eff_prox_th, {8'h00, rnd[7:0]});
            check(eff_touch_th, {6'h00, rnd[15:8], 2'b00});
        end
        wr(PTH_OFS_PROX, 8'h80);
        wr(PTH_OFS_TOUCH, 8'h20);
        for (int b = 0; b < 4; b++) begin
            wr(PTH_OFS_BAND, {2'b00, 2'(3 - b), 2'b00, 2'(b)});
            rel = (b == 0) ? 16'd128 : 16'd128 - (16'd128 >> (b + 1));
            rel_t = (b == 3) ? 16'd128 : 16'd128 - (16'd128 >> (4 - b));
            rel_hi = (rel > rel_t) ? rel : rel_t;
            rel_lo = (rel > rel_t) ? rel_t : rel;
            sample(16'd127, 16'h0);
            check({14'h0, status.prox, status.touch}, 16'h0);
            sample(16'd128, 16'h0);
            check({14'h0, status.prox, status.touch}, 16'h3);
            sample(rel_hi, 16'h0);
            check({14'h0, status.prox, status.touch}, 16'h3);
            sample(rel_hi - 16'd1, 16'h0);
            check({14'h0, status.prox, status.touch},
                  (rel > rel_t) ? 16'h1 : 16'h2);
            sample(rel_lo - 16'd1, 16'h0);
            check({14'h0, status.prox, status.touch}, 16'h0);
        end
        for (int i = 0; i < 3; i++) begin
            wr(PTH_OFS_HALT, halt_tab[i]);
            sample({8'h00, halt_tab[i]} - 16'd1, 16'h0);
            check(16'(status.halt), 16'(halt_tab[i] == 8'h00));
            sample({8'h00, halt_tab[i]}, 16'h0);
            check({15'h0, status.halt}, 16'h1);
        end
        @(posedge clk);
        dual_mode <= 1'b1;
        repeat (2) @(posedge clk);
        rd(PTH_OFS_BAND, 8'h80);
        wr(PTH_OFS_BAND, 8'hff);
        rd(PTH_OFS_BAND, 8'h80);
        rnd = lfsr_next(rnd);
        wr(PTH_OFS_ANT_A_PROX, rnd[7:0]);
        check(eff_prox_th, {8'h00, rnd[7:0]});
        wr(PTH_OFS_ANT_A_TOUCH, 8'h80);
        sample(16'hffff, 16'h0203);
        @(posedge clk);
        #1;
        check(eff_touch_th, 16'h0101);
        check({15'h0, status.halt}, 16'h0);
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule
`default_nettype wire
